// [inc/uefr_pkg.sv]
// constants, field positions and carrier types for the enhanced-feature register bank
// assumes one 10 MHz clock shared by the host port logic and the uart core
package uefr_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [3:0] OFS_RX_COUNT = 4'h5;
    localparam logic [3:0] OFS_TX_FILL = 4'h6;
    localparam logic [3:0] OFS_SPECIAL_FUNC = 4'h7;
    localparam logic [3:0] OFS_IDLE_TIME = 4'h8;
    localparam logic [3:0] OFS_TXRX_CONTROL = 4'h9;
    localparam logic [3:0] OFS_UNLOCK_KEY = 4'hD;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'hF;

    // access keys
    localparam logic [7:0] LINE_CTRL_KEY = 8'hBF;
    localparam logic [7:0] UNLOCK_KEY = 8'h5A;

    // reset values
    localparam logic [7:0] RST_SPECIAL_FUNC = 8'h00;
    localparam logic [7:0] RST_IDLE_TIME = 8'h00;
    localparam logic [7:0] RST_TXRX_CONTROL = 8'h06;
    localparam logic [7:0] RST_UNLOCK_KEY = 8'h00;
    localparam logic [7:0] RST_IRQ_STATUS = 8'h00;

    // special function register fields
    localparam int SF_XTAL_RES_DIS = 7;
    localparam int SF_CNT_SELECT = 6;
    localparam int SF_BURST_EN = 4;
    localparam int SF_LOOPBACK = 3;
    localparam int SF_SPECIAL_ACC = 2;
    localparam int SF_AUTO_DSR_DTR = 1;
    localparam int SF_FORCE_TX = 0;

    // tx/rx control register fields
    localparam int TC_SAMPLE_HI = 7;
    localparam int TC_SAMPLE_LO = 4;
    localparam int TC_XON_INBAND = 3;
    localparam int TC_TX_EMPTY_IRQ = 2;
    localparam int TC_RX_TIMEOUT = 1;
    localparam int TC_IDLE_INSERT = 0;

    // interrupt status register fields
    localparam int IS_CLEAR_BIT = 0;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } uefr_req_s;

    typedef struct packed {
        logic [7:0] specialFunc;
        logic [7:0] unlockKey;
        logic [7:0] idleTime;
        logic [7:0] txrxControl;
        logic [7:1] irqFlags;
        logic [7:0] rdData;
        logic rdValid;
        logic refused;
    } uefr_state_s;

endpackage

// [core/uefr_regs.sv]
// enhanced-feature register bank: tx fill counter, special function, idle time,
// tx/rx control, interrupt status, plus the unlock key that guards special function.
// assumes a one-cycle request strobe from the host-port decoder on the same clock,
// the line control value from the main register file, and counts/events from the uart core.
//
// Overview of operation
// - read-only tx fifo count, gated by keys
// - special function needs line key and unlock key
// - bit7 disables crystal feedback resistor
// - bit6 picks rx fill or error count
// - bit4 enables burst register access
// - bit3 loops receive data to transmitter
// - bit2 gates prescaler, status, idle, control
// - bit1 enables automatic dsr/dtr flow control
// - bit0 forces transmitter to always send
// - eight-bit read/write transmit idle time
// - upper nibble holds baud sample clock value
// - control bit3 enables in-band xon
// - control bit2 enables tx empty interrupt
// - bit0 idle insertion, bit1 rx timeout
// - tx/rx control resets to 0x06
// - status bits 7..1 flag interrupt sources
// - writing bit0 clears status flags not raised in the same cycle
`timescale 1ns/100ps

module uefr_regs
    import uefr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic swReset,
    input wire uefr_pkg::uefr_req_s hostReq,
    input wire logic [7:0] lineControl,
    input wire logic [7:0] txFillCount,
    input wire logic [7:0] rxFillCount,
    input wire logic [7:0] rxErrorCount,
    input wire logic [7:1] irqEvents,
    output logic [7:0] rdData,
    output logic rdValid,
    output logic accessRefused,
    output logic prescalerAccess,
    output logic xtalResistorDisable,
    output logic counterSelect,
    output logic burstEnable,
    output logic loopbackEnable,
    output logic autoDsrDtrEnable,
    output logic forceTransmit,
    output logic [7:0] idleTime,
    output logic [3:0] sampleClock,
    output logic xonInbandEnable,
    output logic txEmptyIrqEnable,
    output logic rxTimeoutEnable,
    output logic idleInsertEnable,
    output logic [7:1] irqFlags
);
    import uefr_pkg::*;

    uefr_state_s stateQ;
    uefr_state_s stateD;

    logic lineKeyOk;
    logic specialFuncOk;
    logic specialAccOk;

    // the line key is re-checked on every access, so a later write of the line
    // control register closes the window without touching this bank
    assign lineKeyOk = (lineControl == LINE_CTRL_KEY);
    assign specialFuncOk = lineKeyOk && (stateQ.unlockKey == UNLOCK_KEY);
    assign specialAccOk = lineKeyOk && stateQ.specialFunc[SF_SPECIAL_ACC];

    function automatic logic addrAllowed(input logic [3:0] a, input logic lk, input logic sf, input logic sa);
        logic ok;
        ok = 1'b0;
        unique case (a)
            OFS_UNLOCK_KEY: ok = lk;
            OFS_SPECIAL_FUNC: ok = sf;
            OFS_RX_COUNT, OFS_TX_FILL, OFS_IDLE_TIME, OFS_TXRX_CONTROL, OFS_IRQ_STATUS: ok = sa;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    logic allowed;
    assign allowed = addrAllowed(hostReq.addr, lineKeyOk, specialFuncOk, specialAccOk);

    always_comb
    begin
        stateD = stateQ;
        stateD.rdValid = 1'b0;
        stateD.refused = 1'b0;
        // sticky event capture; applied after the clear so a same-cycle event survives
        if (hostReq.wr && allowed)
        begin
            unique case (hostReq.addr)
                OFS_UNLOCK_KEY: stateD.unlockKey = hostReq.wdata;
                OFS_SPECIAL_FUNC: stateD.specialFunc = hostReq.wdata;
                OFS_IDLE_TIME: stateD.idleTime = hostReq.wdata;
                OFS_TXRX_CONTROL: stateD.txrxControl = hostReq.wdata;
                OFS_IRQ_STATUS:
                begin
                    // the clear bit is never stored, so it always reads back zero
                    if (hostReq.wdata[IS_CLEAR_BIT])
                    begin
                        stateD.irqFlags = '0;
                    end
                end
                default:
                begin
                    // read-only counters ignore writes
                end
            endcase
        end
        stateD.irqFlags = stateD.irqFlags | irqEvents;
        if (hostReq.rd)
        begin
            stateD.rdValid = 1'b1;
            stateD.rdData = 8'h00;
            if (allowed)
            begin
                unique case (hostReq.addr)
                    OFS_UNLOCK_KEY: stateD.rdData = stateQ.unlockKey;
                    OFS_SPECIAL_FUNC: stateD.rdData = stateQ.specialFunc;
                    OFS_TX_FILL: stateD.rdData = txFillCount;
                    OFS_RX_COUNT: stateD.rdData = stateQ.specialFunc[SF_CNT_SELECT] ?
                        rxErrorCount : rxFillCount;
                    OFS_IDLE_TIME: stateD.rdData = stateQ.idleTime;
                    OFS_TXRX_CONTROL: stateD.rdData = stateQ.txrxControl;
                    OFS_IRQ_STATUS: stateD.rdData = {stateQ.irqFlags, 1'b0};
                    default: stateD.rdData = 8'h00;
                endcase
            end
        end
        // blocked accesses read zero and drop writes; the flag lets the port logic nack
        if ((hostReq.rd || hostReq.wr) && !allowed)
        begin
            stateD.refused = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b || swReset)
        begin
            stateQ.specialFunc <= RST_SPECIAL_FUNC;
            stateQ.unlockKey <= RST_UNLOCK_KEY;
            stateQ.idleTime <= RST_IDLE_TIME;
            stateQ.txrxControl <= RST_TXRX_CONTROL;
            stateQ.irqFlags <= RST_IRQ_STATUS[7:1];
            stateQ.rdData <= 8'h00;
            stateQ.rdValid <= 1'b0;
            stateQ.refused <= 1'b0;
        end
        else
        begin
            stateQ <= stateD;
        end
    end

    // prescaler lives elsewhere; it only receives this bank's gate, registered
    logic prescalerAccessQ;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            prescalerAccessQ <= 1'b0;
        end
        else
        begin
            prescalerAccessQ <= specialAccOk;
        end
    end

    assign rdData = stateQ.rdData;
    assign rdValid = stateQ.rdValid;
    assign accessRefused = stateQ.refused;
    assign prescalerAccess = prescalerAccessQ;
    assign xtalResistorDisable = stateQ.specialFunc[SF_XTAL_RES_DIS];
    assign counterSelect = stateQ.specialFunc[SF_CNT_SELECT];
    assign burstEnable = stateQ.specialFunc[SF_BURST_EN];
    assign loopbackEnable = stateQ.specialFunc[SF_LOOPBACK];
    assign autoDsrDtrEnable = stateQ.specialFunc[SF_AUTO_DSR_DTR];
    assign forceTransmit = stateQ.specialFunc[SF_FORCE_TX];
    assign idleTime = stateQ.idleTime;
    // legality of sample value against the prescaler is software's job, not checked here
    assign sampleClock = stateQ.txrxControl[TC_SAMPLE_HI:TC_SAMPLE_LO];
    assign xonInbandEnable = stateQ.txrxControl[TC_XON_INBAND];
    assign txEmptyIrqEnable = stateQ.txrxControl[TC_TX_EMPTY_IRQ];
    assign rxTimeoutEnable = stateQ.txrxControl[TC_RX_TIMEOUT];
    assign idleInsertEnable = stateQ.txrxControl[TC_IDLE_INSERT];
    assign irqFlags = stateQ.irqFlags;

    // ---------------- assertions ----------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b || swReset);

    sequence s_fillRead;
        hostReq.rd && hostReq.addr == OFS_TX_FILL;
    endsequence

    sequence s_sfWrite;
        hostReq.wr && hostReq.addr == OFS_SPECIAL_FUNC;
    endsequence

    sequence s_clearWrite;
        hostReq.wr && hostReq.addr == OFS_IRQ_STATUS && hostReq.wdata[IS_CLEAR_BIT] && specialAccOk;
    endsequence

    a_fill_read_ok: assert property (s_fillRead and (specialAccOk) |=> rdValid && rdData == $past(txFillCount))
        else $error("tx fill count read wrong");

    a_fill_read_block: assert property (s_fillRead and (!specialAccOk) |=> rdValid && accessRefused && rdData == 8'h00)
        else $error("blocked fill read not refused");

    a_sf_key_gate: assert property (s_sfWrite and (!(lineControl == LINE_CTRL_KEY && stateQ.unlockKey == UNLOCK_KEY))
        |=> $stable(stateQ.specialFunc))
        else $error("special function written without keys");

    a_sf_loop_write: assert property (s_sfWrite and (specialFuncOk) |=> loopbackEnable == $past(hostReq.wdata[3])
        && forceTransmit == $past(hostReq.wdata[0]))
        else $error("special function write not applied");

    a_cnt_select: assert property (hostReq.rd && hostReq.addr == OFS_RX_COUNT && specialAccOk
        |=> rdData == ($past(counterSelect) ? $past(rxErrorCount) : $past(rxFillCount)))
        else $error("counter view mux wrong");

    a_ctrl_gate: assert property (hostReq.wr && hostReq.addr == OFS_TXRX_CONTROL && !specialAccOk
        |=> $stable(stateQ.txrxControl))
        else $error("control written while gated");

    a_idle_write: assert property (hostReq.wr && hostReq.addr == OFS_IDLE_TIME && specialAccOk
        |=> idleTime == $past(hostReq.wdata))
        else $error("idle time write lost");

    a_clear_flags: assert property (s_clearWrite ##0 (irqEvents == 7'h00) |=> irqFlags == 7'h00 ##1 rdData[0] == 1'b0)
        else $error("status clear failed");

    a_event_wins: assert property (s_clearWrite ##0 irqEvents[7] |=> irqFlags[7])
        else $error("event lost during clear");

    a_reset_defaults: assert property (disable iff (1'b0) (!rst_b || swReset) |=> stateQ.txrxControl == RST_TXRX_CONTROL
        && stateQ.specialFunc == RST_SPECIAL_FUNC && irqFlags == 7'h00)
        else $error("reset defaults wrong");

    sequence s_ctrlWrite;
        hostReq.wr && hostReq.addr == OFS_TXRX_CONTROL && specialAccOk;
    endsequence

    sequence s_unlockWrite;
        hostReq.wr && hostReq.addr == OFS_UNLOCK_KEY;
    endsequence

    sequence s_noClear;
        !(hostReq.wr && hostReq.addr == OFS_IRQ_STATUS && hostReq.wdata[IS_CLEAR_BIT] && specialAccOk);
    endsequence

    // every read is answered, allowed or not, so the port logic never waits
    a_read_valid: assert property (hostReq.rd |=> rdValid)
        else $error("read not answered");

    a_valid_pulse: assert property (!hostReq.rd |=> !rdValid)
        else $error("read valid without read");

    a_refuse_pulse: assert property (!(hostReq.rd || hostReq.wr) |=> !accessRefused)
        else $error("refusal without access");

    a_blocked_zero: assert property (hostReq.rd && !allowed
        |=> rdData == 8'h00 && accessRefused)
        else $error("blocked read leaked data");

    a_tx_fill_ro: assert property (hostReq.wr && hostReq.addr == OFS_TX_FILL && specialAccOk
        |=> !accessRefused)
        else $error("fill counter write refused");

    a_unlock_gate: assert property (s_unlockWrite and (lineControl != LINE_CTRL_KEY)
        |=> $stable(stateQ.unlockKey))
        else $error("unlock key written without line key");

    a_unlock_write: assert property (s_unlockWrite and (lineControl == LINE_CTRL_KEY)
        |=> stateQ.unlockKey == $past(hostReq.wdata))
        else $error("unlock key write lost");

    a_sf_other_bits: assert property (s_sfWrite and (specialFuncOk)
        |=> {xtalResistorDisable, counterSelect, burstEnable, autoDsrDtrEnable}
        == {$past(hostReq.wdata[7]), $past(hostReq.wdata[6]), $past(hostReq.wdata[4]), $past(hostReq.wdata[1])})
        else $error("special function bits not applied");

    a_ctrl_write: assert property (s_ctrlWrite
        |=> {sampleClock, xonInbandEnable, txEmptyIrqEnable, rxTimeoutEnable, idleInsertEnable}
        == $past(hostReq.wdata))
        else $error("control write not applied");

    a_idle_gate: assert property (hostReq.wr && hostReq.addr == OFS_IDLE_TIME && !specialAccOk
        |=> $stable(idleTime))
        else $error("idle time written while gated");

    a_status_gate: assert property (hostReq.wr && hostReq.addr == OFS_IRQ_STATUS && !specialAccOk
        && irqEvents == 7'h00 |=> $stable(irqFlags))
        else $error("status cleared while gated");

    // flags only accumulate between clears; nothing else may drop one
    a_flags_sticky: assert property (s_noClear
        |=> irqFlags == ($past(irqFlags) | $past(irqEvents)))
        else $error("status flag lost");

    a_status_read: assert property (hostReq.rd && hostReq.addr == OFS_IRQ_STATUS && specialAccOk
        |=> rdData == {$past(irqFlags), 1'b0})
        else $error("status read wrong");

    a_prescaler_gate: assert property (1'b1 |=> prescalerAccess == $past(specialAccOk))
        else $error("prescaler gate wrong");

    a_reset_idle: assert property (disable iff (1'b0) (!rst_b || swReset)
        |=> idleTime == RST_IDLE_TIME && stateQ.unlockKey == RST_UNLOCK_KEY)
        else $error("idle or unlock default wrong");

    a_reset_quiet: assert property (disable iff (1'b0) (!rst_b || swReset)
        |=> !rdValid && !accessRefused && rdData == 8'h00)
        else $error("port outputs not quiet after reset");

endmodule

// [sim/uefr_host_model.sv]
// host model: issues one-cycle register requests and collects the answers
// assumes requests change on the falling edge and answers are registered on the rising edge
`timescale 1ns/100ps

module uefr_host_model
    import uefr_pkg::*;
(
    input wire logic clk,
    output uefr_pkg::uefr_req_s hostReq,
    input wire logic [7:0] rdData,
    input wire logic rdValid,
    input wire logic accessRefused
);
    initial hostReq = '0;

    // the answer lands one edge after the request edge, so it is read at the next falling edge
    task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic v, output logic r);
        @(negedge clk);
        hostReq = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
        q = rdData;
        v = rdValid;
        r = accessRefused;
        // released fields are inverted so a stale value cannot pass for a live one
        hostReq = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic unlock(output logic r);
        logic [7:0] q;
        logic v;
        access(1'b1, OFS_UNLOCK_KEY, UNLOCK_KEY, q, v, r);
    endtask
endmodule

// [sim/testbench.sv]
// self-checking bench for the enhanced-feature register bank
// assumes the host model drives requests; core-side inputs are driven here on the falling edge
`timescale 1ns/100ps

`define CHK(got, exp) \
    begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module testbench;
    import uefr_pkg::*;
    logic clk = 0;
    logic rst_b = 0;
    logic swReset = 0;
    logic [7:0] lineControl = 8'h00;
    logic [7:0] txFillCount = 8'h2C;
    logic [7:0] rxFillCount = 8'h13;
    logic [7:0] rxErrorCount = 8'h31;
    logic [7:1] irqEvents = 7'h00;
    uefr_req_s hostReq;
    logic [7:0] rdData, idleTime, sf, tr;
    logic [3:0] sampleClock;
    logic [7:1] irqFlags;
    logic rdValid, accessRefused, prescalerAccess, xtalResistorDisable, counterSelect, burstEnable;
    logic loopbackEnable, autoDsrDtrEnable, forceTransmit, xonInbandEnable, txEmptyIrqEnable;
    logic rxTimeoutEnable, idleInsertEnable, r;
    int n_errors = 0;
    int tests_run = 0;

    always #50 clk = ~clk;

    uefr_host_model host_u (.clk(clk), .hostReq(hostReq), .rdData(rdData), .rdValid(rdValid),
        .accessRefused(accessRefused));

    uefr_regs dut_u (.clk(clk), .rst_b(rst_b), .swReset(swReset), .hostReq(hostReq),
        .lineControl(lineControl), .txFillCount(txFillCount), .rxFillCount(rxFillCount),
        .rxErrorCount(rxErrorCount), .irqEvents(irqEvents), .rdData(rdData), .rdValid(rdValid),
        .accessRefused(accessRefused), .prescalerAccess(prescalerAccess),
        .xtalResistorDisable(xtalResistorDisable), .counterSelect(counterSelect),
        .burstEnable(burstEnable), .loopbackEnable(loopbackEnable), .autoDsrDtrEnable(autoDsrDtrEnable),
        .forceTransmit(forceTransmit), .idleTime(idleTime), .sampleClock(sampleClock),
        .xonInbandEnable(xonInbandEnable), .txEmptyIrqEnable(txEmptyIrqEnable),
        .rxTimeoutEnable(rxTimeoutEnable), .idleInsertEnable(idleInsertEnable), .irqFlags(irqFlags));

    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic f);
        logic [7:0] q;
        logic v, x;
        host_u.access(1'b0, a, 8'h00, q, v, x);
        `CHK(v, 1'b1)
        `CHK(q, e)
        `CHK(x, f)
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic f);
        logic [7:0] q;
        logic v, x;
        host_u.access(1'b1, a, d, q, v, x);
        `CHK(x, f)
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #300000;
        n_errors++;
        conclude();
    end

    initial
    begin
        repeat (8) @(negedge clk);
        rst_b = 1;
        rd(OFS_SPECIAL_FUNC, 8'h00, 1'b1);
        lineControl = LINE_CTRL_KEY;
        rd(OFS_SPECIAL_FUNC, 8'h00, 1'b1);
        rd(OFS_TX_FILL, 8'h00, 1'b1);
        rd(4'hA, 8'h00, 1'b1);
        host_u.unlock(r);
        `CHK(r, 1'b0)
        $display("test gating done");
        // both patterns keep the special access bit set
        for (int i = 0; i < 2; i++)
        begin
            sf = i ? 8'h4D : 8'h96;
            wr(OFS_SPECIAL_FUNC, sf, 1'b0);
            rd(OFS_SPECIAL_FUNC, sf, 1'b0);
            `CHK({xtalResistorDisable, counterSelect, burstEnable}, {sf[7], sf[6], sf[4]})
            `CHK({loopbackEnable, autoDsrDtrEnable, forceTransmit}, {sf[3], sf[1], sf[0]})
        end
        `CHK(prescalerAccess, 1'b1)
        rd(OFS_RX_COUNT, rxErrorCount, 1'b0);
        wr(OFS_SPECIAL_FUNC, 8'h04, 1'b0);
        rd(OFS_RX_COUNT, rxFillCount, 1'b0);
        rd(OFS_TX_FILL, 8'h2C, 1'b0);
        wr(OFS_TX_FILL, 8'hFF, 1'b0);
        rd(OFS_TX_FILL, 8'h2C, 1'b0);
        $display("test special function done");
        rd(OFS_TXRX_CONTROL, RST_TXRX_CONTROL, 1'b0);
        rd(OFS_IDLE_TIME, 8'h00, 1'b0);
        wr(OFS_IDLE_TIME, 8'hA5, 1'b0);
        rd(OFS_IDLE_TIME, 8'hA5, 1'b0);
        `CHK(idleTime, 8'hA5)
        // the bank does not check sample legality, so any sample value is written
        for (int i = 0; i < 2; i++)
        begin
            tr = i ? 8'h46 : 8'hB9;
            wr(OFS_TXRX_CONTROL, tr, 1'b0);
            `CHK({sampleClock, xonInbandEnable, txEmptyIrqEnable}, tr[7:2])
            `CHK({rxTimeoutEnable, idleInsertEnable}, tr[1:0])
        end
        $display("test control done");
        @(negedge clk);
        irqEvents = 7'h55;
        @(negedge clk);
        irqEvents = 7'h00;
        `CHK(irqFlags, 7'h55)
        rd(OFS_IRQ_STATUS, 8'hAA, 1'b0);
        wr(OFS_IRQ_STATUS, 8'h01, 1'b0);
        `CHK(irqFlags, 7'h00)
        rd(OFS_IRQ_STATUS, 8'h00, 1'b0);
        $display("test status done");
        @(negedge clk);
        swReset = 1;
        @(negedge clk);
        swReset = 0;
        `CHK({sampleClock, txEmptyIrqEnable, rxTimeoutEnable}, 6'b0000_11)
        `CHK(idleTime, 8'h00)
        rd(OFS_SPECIAL_FUNC, 8'h00, 1'b1);
        $display("test soft reset done");
        conclude();
    end
endmodule
